// *** hdl/asr_status_regs.sv ***
// AXI4-Lite slave for the converter status, identity and revision bytes.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
//
// Notes on behaviour
// - Unsigned 8-bit temperature code; degrees are code minus 78.
// - Temperature reading is valid only while the sensor enable is set.
// - Error status bits 7..1 and reserved register read zero always.
// - Redundant config copies; error bit set when any copy disagrees.
// - 64-bit die identifier as eight read-only bytes at 0x17..0x1e.
// - Read-only factory revision byte at index 0x1f.
// - Temperature byte read-only at index 0x08, follows sensor while enabled, else holds.
module asr_status_regs #(
    parameter logic [63:0] UNIQUE_DIE_IDENTIFIER = 64'h0123_4567_89ab_cdef, // arbitrary
    parameter logic [7:0] DIE_REV = 8'h01 // arbitrary
) (
    input wire logic clock, // 25 MHz clock
    input wire logic reset, // asynchronous, active high
    input wire logic [7:0] sensor_code, // raw temperature sensor code
    input wire logic [asr_pkg::CFG_REGS*asr_pkg::CFG_COPIES*8-1:0]
        cfg_copies, // all copies of config bytes 0x00..0x07
    output logic temp_valid, // sensor reading currently valid
    output logic cfg_error, // integrity error flag
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready // read data ready
);
    import asr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Configuration integrity compare.
    logic [CFG_REGS-1:0] byte_mismatch;
    genvar gi;
    generate
        for (gi = 0; gi < CFG_REGS; gi++) begin : g_cmp
            logic [7:0] c0;
            logic [7:0] c1;
            logic [7:0] c2;
            assign c0 = cfg_copies[(gi*CFG_COPIES+0)*8 +: 8];
            assign c1 = cfg_copies[(gi*CFG_COPIES+1)*8 +: 8];
            assign c2 = cfg_copies[(gi*CFG_COPIES+2)*8 +: 8];
            assign byte_mismatch[gi] = (c0 != c1) || (c0 != c2);
        end
    endgenerate

    wire any_mismatch = |byte_mismatch;
    // Copy 0 of byte 0x05 is the live sensor enable.
    wire sensor_en =
        cfg_copies[(int'(IDX_CFG_TEMP_EN)*CFG_COPIES)*8 + CFG_TEMP_EN_BIT];

    logic err_reg;
    asr_temp_t temp_reg;

    // The flag is sticky-free: it tracks the current comparison, so a
    // transient upset that is scrubbed clears the indication again.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            err_reg <= 1'b0;
            temp_reg <= '0;
        end else begin
            err_reg <= any_mismatch;
            temp_reg.valid <= sensor_en;
            if (sensor_en) begin
                temp_reg.code <= sensor_code;
            end
        end
    end

    assign temp_valid = temp_reg.valid;
    assign cfg_error = err_reg;

    ////////////////////////////////////////////////////////////////////////
    // Read decode.
    function automatic logic [8:0] rd_decode(input logic [7:0] idx,
                                             input asr_temp_t t,
                                             input logic e);
        logic [2:0] sel;
        sel = 3'(idx - IDX_UNIQUE_DIE_IDENTIFIER_FIRST);
        rd_decode = {1'b1, 8'h00};
        if (idx == IDX_TEMP) begin
            rd_decode = {1'b1, t.code};
        end else if (idx == IDX_INTEGRITY) begin
            rd_decode = {1'b1, 7'h00, e};
        end else if (idx == IDX_RSVD) begin
            rd_decode = {1'b1, RSVD_VALUE};
        end else if (idx >= IDX_UNIQUE_DIE_IDENTIFIER_FIRST && idx <= IDX_UNIQUE_DIE_IDENTIFIER_LAST) begin
            rd_decode = {1'b1, UNIQUE_DIE_IDENTIFIER[sel*8 +: 8]};
        end else if (idx == IDX_DIE_REV) begin
            rd_decode = {1'b1, DIE_REV};
        end else begin
            rd_decode = {1'b0, 8'h00};
        end
    endfunction : rd_decode

    wire [7:0] rd_idx = {2'h0, s_axi_araddr[7:2]};
    wire [8:0] rd_hit = rd_decode(rd_idx, temp_reg, err_reg);
    wire [7:0] wr_idx = {2'h0, s_axi_awaddr[7:2]};
    wire [8:0] wr_hit = rd_decode(wr_idx, temp_reg, err_reg);

    ////////////////////////////////////////////////////////////////////////
    // Read channel: one cycle from address handshake to rvalid.
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else if (rvalid_reg) begin
            if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end else if (arready_reg && s_axi_arvalid) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= {24'h0, rd_hit[7:0]};
            rresp_reg <= rd_hit[8] ? RESP_OKAY : RESP_DECERR;
        end else begin
            arready_reg <= 1'b1;
        end
    end
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data in either order, nothing stored.
    asr_wstate_t wstate_reg;
    logic aw_got_reg;
    logic w_got_reg;
    logic awready_reg;
    logic wready_reg;
    logic [1:0] bresp_reg;
    logic aw_hit_reg;
    logic bvalid_reg;
    wire aw_fire = awready_reg && s_axi_awvalid;
    wire w_fire = wready_reg && s_axi_wvalid;
    wire aw_done = aw_got_reg || aw_fire;
    wire w_done = w_got_reg || w_fire;
    wire hit_now = aw_fire ? wr_hit[8] : aw_hit_reg;
    wire [1:0] wr_resp = hit_now ? RESP_SLVERR : RESP_DECERR;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wstate_reg <= ASR_W_IDLE;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            aw_hit_reg <= 1'b0;
            bvalid_reg <= 1'b0;
        end else begin
            case (wstate_reg)
                ASR_W_IDLE: begin
                    awready_reg <= !aw_done;
                    wready_reg <= !w_done;
                    aw_got_reg <= aw_done;
                    w_got_reg <= w_done;
                    if (aw_fire) begin
                        aw_hit_reg <= wr_hit[8];
                    end
                    if (aw_done && w_done) begin
                        // Every mapped byte is read-only: answer SLVERR, store nothing.
                        bresp_reg <= wr_resp;
                        bvalid_reg <= 1'b1;
                        wstate_reg <= ASR_W_RESP;
                        awready_reg <= 1'b0;
                        wready_reg <= 1'b0;
                    end
                end
                ASR_W_RESP: begin
                    if (s_axi_bready) begin
                        bvalid_reg <= 1'b0;
                        wstate_reg <= ASR_W_IDLE;
                        aw_got_reg <= 1'b0;
                        w_got_reg <= 1'b0;
                    end
                end
                default: wstate_reg <= ASR_W_IDLE;
            endcase
        end
    end
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    // The integrity flag must follow the comparison in both directions.
    a_err_tracks_copy: assert property (
        @(posedge clock) disable iff (reset)
        any_mismatch |=> cfg_error)
        else $error("integrity flag missed a copy mismatch");
    a_err_clears: assert property (
        @(posedge clock) disable iff (reset)
        !any_mismatch |=> !cfg_error)
        else $error("integrity flag stayed up after copies agreed");
    a_temp_invalid_off: assert property (
        @(posedge clock) disable iff (reset)
        !sensor_en |=> !temp_valid ##0 $stable(temp_reg.code))
        else $error("temperature updated while sensor disabled");
    a_temp_valid_on: assert property (
        @(posedge clock) disable iff (reset)
        sensor_en |=> temp_valid)
        else $error("temperature not marked valid while enabled");
    a_temp_follows: assert property (
        @(posedge clock) disable iff (reset)
        sensor_en |=> temp_reg.code == $past(sensor_code))
        else $error("temperature byte does not follow sensor");
    a_temp_read_value: assert property (
        @(posedge clock) disable iff (reset)
        (s_axi_arvalid && s_axi_arready && rd_idx == IDX_TEMP)
        |=> s_axi_rdata == {24'h0, $past(temp_reg.code)})
        else $error("temperature read returned a stale byte");
    a_status_upper_zero: assert property (
        @(posedge clock) disable iff (reset)
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_rsvd_reads_zero: assert property (
        @(posedge clock) disable iff (reset)
        (s_axi_arvalid && s_axi_arready && rd_idx == IDX_RSVD)
        |=> s_axi_rdata == 32'h0)
        else $error("reserved register read nonzero");
    a_int_upper_zero: assert property (
        @(posedge clock) disable iff (reset)
        (s_axi_arvalid && s_axi_arready && rd_idx == IDX_INTEGRITY)
        |=> s_axi_rdata == {31'h0, $past(cfg_error)})
        else $error("integrity register content wrong");
    a_rev_value: assert property (
        @(posedge clock) disable iff (reset)
        (s_axi_arvalid && s_axi_arready && rd_idx == IDX_DIE_REV)
        |=> s_axi_rdata == {24'h0, DIE_REV})
        else $error("revision byte wrong");
    a_id_first_byte: assert property (
        @(posedge clock) disable iff (reset)
        (s_axi_arvalid && s_axi_arready && rd_idx == IDX_UNIQUE_DIE_IDENTIFIER_FIRST)
        |=> s_axi_rdata == {24'h0, UNIQUE_DIE_IDENTIFIER[7:0]})
        else $error("die identifier low byte wrong");
    a_write_no_effect: assert property (
        @(posedge clock) disable iff (reset)
        s_axi_bvalid |-> s_axi_bresp != RESP_OKAY)
        else $error("write to read-only space acknowledged as stored");
    a_temp_code_stable: assert property (
        @(posedge clock) disable iff (reset)
        (aw_fire && !sensor_en) |=> $stable(temp_reg.code))
        else $error("write disturbed temperature byte");
    // The gap between the reserved byte and the identifier is unmapped.
    a_unmapped_decerr: assert property (
        @(posedge clock) disable iff (reset)
        (s_axi_arvalid && s_axi_arready && rd_idx > IDX_RSVD
            && rd_idx < IDX_UNIQUE_DIE_IDENTIFIER_FIRST)
        |=> s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_read_ends: assert property (
        @(posedge clock) disable iff (reset)
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && !s_axi_arready)
        else $error("read answer did not end when taken");
    a_write_ends: assert property (
        @(posedge clock) disable iff (reset)
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer did not end when taken");

    // One check per identifier byte pins the byte order down.
    generate
        for (gi = 0; gi < ID_BYTES; gi++) begin : g_id_chk
            a_id_byte_value: assert property (
                @(posedge clock) disable iff (reset)
                (s_axi_arvalid && s_axi_arready
                    && rd_idx == IDX_UNIQUE_DIE_IDENTIFIER_FIRST + 8'(gi))
                |=> s_axi_rdata == {24'h0, UNIQUE_DIE_IDENTIFIER[gi*8 +: 8]})
                else $error("die identifier byte out of order");
        end
    endgenerate

    // Covers for the main scenarios: reads, refusals, errors and writes.
    c_read_temp: cover property (@(posedge clock) disable iff (reset)
        s_axi_arvalid && s_axi_arready && rd_idx == IDX_TEMP);
    c_read_refused: cover property (@(posedge clock) disable iff (reset)
        s_axi_rvalid && s_axi_rresp == RESP_DECERR);
    c_mismatch: cover property (@(posedge clock) disable iff (reset)
        $rose(cfg_error));
    c_write_done: cover property (@(posedge clock) disable iff (reset)
        s_axi_bvalid && s_axi_bready);
    // Write data is dropped on purpose; this shows nonzero data was offered.
    c_write_data: cover property (@(posedge clock) disable iff (reset)
        s_axi_wvalid && s_axi_wready && |s_axi_wstrb && |s_axi_wdata);
endmodule : asr_status_regs

// *** hdl/asr_pkg.sv ***
// Package with register map, field layout and bus response constants.
package asr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Printed offsets are not all multiples of four: index times four.
    localparam logic [7:0] IDX_CFG_TEMP_EN = 8'h05;
    localparam logic [7:0] IDX_TEMP = 8'h08;
    localparam logic [7:0] IDX_INTEGRITY = 8'h09;
    localparam logic [7:0] IDX_RSVD = 8'h0a;
    localparam logic [7:0] IDX_UNIQUE_DIE_IDENTIFIER_FIRST = 8'h17;
    localparam logic [7:0] IDX_UNIQUE_DIE_IDENTIFIER_LAST = 8'h1e;
    localparam logic [7:0] IDX_DIE_REV = 8'h1f;
    localparam logic [7:0] IDX_CFG_COPY0 = 8'h00;
    localparam logic [7:0] IDX_CFG_COPY7 = 8'h07;
    localparam int CFG_TEMP_EN_BIT = 7;
    localparam int INTEGRITY_ERR_BIT = 0;
    localparam logic [7:0] TEMP_OFFSET_C = 8'h4e;
    localparam logic [7:0] INTEGRITY_RESET = 8'h00;
    localparam logic [7:0] RSVD_VALUE = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    localparam int CFG_REGS = 8;
    localparam int CFG_COPIES = 3;
    localparam int ID_BYTES = 8;

    typedef struct packed {
        logic [7:0] code;
        logic valid;
    } asr_temp_t;

    typedef enum logic [1:0] {
        ASR_W_IDLE,
        ASR_W_RESP
    } asr_wstate_t;
endpackage : asr_pkg

// *** verif/tb_asr_status_regs.sv ***
// Self-checking bench for the status, identity and revision register block.
`timescale 1ns/1ps
module tb_asr_status_regs;
    import asr_pkg::*;
    localparam logic [63:0] ID = 64'h5a17_c3e2_0b94_d6f8; // arbitrary
    localparam logic [7:0] REV = 8'h3c; // arbitrary
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [7:0] sensor_code = 8'h00;
    logic [CFG_REGS*CFG_COPIES*8-1:0] cfg_copies = '0;
    logic temp_valid, cfg_error;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [33:0] rd_q[$];
    logic [1:0] wr_q[$];
    int failures = 0, compares = 0, cycles = 0;
    logic [31:0] rng = 32'h2fa9c335;
    logic [7:0] held;
    logic [7:0] codes [4] = '{8'h00, 8'h73, 8'haf, 8'hff};
    logic [7:0] ro_idx [5] = '{IDX_TEMP, IDX_INTEGRITY, IDX_RSVD,
        IDX_UNIQUE_DIE_IDENTIFIER_FIRST, IDX_DIE_REV};

    asr_status_regs #(.UNIQUE_DIE_IDENTIFIER(ID), .DIE_REV(REV)) asr_status_regs_inst (
        .clock(clock), .reset(reset), .sensor_code(sensor_code),
        .cfg_copies(cfg_copies), .temp_valid(temp_valid),
        .cfg_error(cfg_error), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    initial begin
        forever #20 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction : xs

    task automatic check(input string name, input logic [33:0] seen,
                         input logic [33:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    task automatic report_and_stop;
        $display("compares %0d, failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    // The master holds each request until its ready is sampled at an edge.
    task automatic rd(input logic [7:0] idx, input logic [1:0] resp,
                      input logic [7:0] d);
        rd_q.push_back({resp, 24'h0, d});
        s_axi_araddr <= {idx[5:0], 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clock); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clock); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge clock);
    endtask : rd

    task automatic wr(input logic [7:0] idx, input logic [1:0] resp);
        logic aw = 1'b0;
        logic w = 1'b0;
        logic zero_only;
        zero_only = (idx == IDX_INTEGRITY) || (idx == IDX_RSVD);
        wr_q.push_back(resp);
        rng = xs(rng);
        s_axi_awaddr <= {idx[5:0], 2'b00};
        s_axi_wdata <= zero_only ? 32'h0 : rng;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clock); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge clock);
    endtask : wr

    task automatic set_byte(input int r, input logic [7:0] v);
        for (int c = 0; c < CFG_COPIES; c++) begin
            cfg_copies[(r*CFG_COPIES+c)*8 +: 8] <= v;
        end
        repeat (3) @(posedge clock);
    endtask : set_byte

    ////////////////////////////////////////////////////////////////////////
    // Watcher: each answer is compared against the oldest noted expectation.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (s_axi_rvalid && s_axi_rready) begin
            check("read", {s_axi_rresp, s_axi_rdata},
                rd_q.pop_front());
        end
        if (s_axi_bvalid && s_axi_bready) begin
            check("bresp", {32'h0, s_axi_bresp},
                {32'h0, wr_q.pop_front()});
        end
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end

    initial begin
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        rd(IDX_INTEGRITY, RESP_OKAY, 8'h00);
        rd(IDX_RSVD, RESP_OKAY, 8'h00);
        for (int k = 0; k < ID_BYTES; k++) begin
            rd(IDX_UNIQUE_DIE_IDENTIFIER_FIRST + 8'(k), RESP_OKAY, ID[8*k +: 8]);
        end
        rd(IDX_DIE_REV, RESP_OKAY, REV);
        set_byte(IDX_CFG_TEMP_EN, 8'h80);
        rng = xs(rng);
        codes[3] = rng[7:0];
        foreach (codes[i]) begin
            sensor_code <= codes[i];
            repeat (3) @(posedge clock);
            check("temp_valid", temp_valid, 34'h1);
            rd(IDX_TEMP, RESP_OKAY, codes[i]);
        end
        set_byte(IDX_CFG_TEMP_EN, 8'h00);
        held = sensor_code;
        sensor_code <= ~held;
        repeat (3) @(posedge clock);
        check("temp_valid", temp_valid, 34'h0);
        rd(IDX_TEMP, RESP_OKAY, held);
        // One stray copy of byte 2 raises the flag only while it lasts.
        cfg_copies[(2*CFG_COPIES+1)*8 +: 8] <= 8'h55;
        repeat (3) @(posedge clock);
        check("cfg_error", cfg_error, 34'h1);
        rd(IDX_INTEGRITY, RESP_OKAY, 8'h01);
        set_byte(2, 8'h00);
        check("cfg_error", cfg_error, 34'h0);
        rd(IDX_INTEGRITY, RESP_OKAY, 8'h00);
        foreach (ro_idx[i]) begin
            wr(ro_idx[i], RESP_SLVERR);
        end
        wr(8'h10, RESP_DECERR);
        rd(8'h10, RESP_DECERR, 8'h00);
        rd(IDX_INTEGRITY, RESP_OKAY, 8'h00);
        rd(IDX_RSVD, RESP_OKAY, 8'h00);
        rd(IDX_UNIQUE_DIE_IDENTIFIER_FIRST, RESP_OKAY, ID[7:0]);
        rd(IDX_DIE_REV, RESP_OKAY, REV);
        rd(IDX_TEMP, RESP_OKAY, held);
        report_and_stop();
    end
endmodule : tb_asr_status_regs
